// ### shared/ppm_pkg.sv
package ppm_pkg;
  // Pin vector layout: index 0 is port A bit 0, indexes 1 to 8 are port B bits 0 to 7
  localparam int NPIN = 9;
  localparam int PA_BIT = 0;
  localparam int PB_LO = 1;
  localparam int PB_HI = 8;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFF_PA_DATA = 8'h00;
  localparam logic [7:0] OFF_PA_DIR = 8'h04;
  localparam logic [7:0] OFF_PA_PULL = 8'h08;
  localparam logic [7:0] OFF_PA_DIER = 8'h0C;
  localparam logic [7:0] OFF_PB_DATA = 8'h10;
  localparam logic [7:0] OFF_PB_DIR = 8'h14;
  localparam logic [7:0] OFF_PB_PULL = 8'h18;
  localparam logic [7:0] OFF_PB_DIER = 8'h1C;
  localparam logic [7:0] OFF_FUNC_SEL = 8'h20;
  localparam logic [7:0] OFF_CMP_ROUTE = 8'h24;
  localparam logic [7:0] OFF_PIN_STATE = 8'h28;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;

  // Reset values
  localparam logic [8:0] RST_DATA = 9'h000;
  localparam logic [8:0] RST_DIR = 9'h000;
  localparam logic [8:0] RST_PULL = 9'h000;
  localparam logic [8:0] RST_DIER = 9'h1FF;
  localparam logic [17:0] RST_FUNC = 18'h00000;
  localparam logic [1:0] RST_CMP = 2'h0;
  localparam logic [2:0] RST_MASK = 3'h0;

  // Function select field: two bits per pin index, field i at [2i+1:2i]
  localparam int FSEL_W = 2;
  localparam logic [1:0] FSEL_GPIO = 2'h0;
  localparam logic [1:0] FSEL_A = 2'h1;
  localparam logic [1:0] FSEL_B = 2'h2;
  localparam logic [1:0] FSEL_C = 2'h3;

  // Which pins offer each alternate code
  localparam logic [8:0] AVAIL_A = 9'h1FB;
  localparam logic [8:0] AVAIL_B = 9'h1E9;
  localparam logic [8:0] AVAIL_C = 9'h001;
  // Codes that release the pad to the LCD half-supply bias
  localparam logic [8:0] ANALOG_A = 9'h002;
  localparam logic [8:0] ANALOG_C = 9'h001;

  // Comparator minus routing bits
  localparam int CMP_SRC_TWO_BIT = 0;
  localparam int CMP_SRC_THREE_BIT = 1;
  localparam int CMP_SRC_TWO_PIN = 7;
  localparam int CMP_SRC_THREE_PIN = 8;

  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_LINE_ZERO = 0;
  localparam int IRQ_LINE_ONE = 1;
  localparam int IRQ_WAKE = 2;

  // Pin state register layout
  localparam int STATE_PB_LSB = 8;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### rtl/ppm_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser with a change detector on the settled stage
module ppm_sync #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q,
  output logic [WIDTH-1:0] chg
);
  logic [WIDTH-1:0] meta; // First stage, read by the second stage only
  logic [WIDTH-1:0] last; // Previous settled value
  logic [1:0] fill; // Edges since reset; history is valid once it saturates

  ////////////////////////////////////////////////////////////////////
  // Synchroniser stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

  // History for edge detection; a pad held high across reset must not look like an edge,
  // so changes are ignored until both stages and the history hold real samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last <= '0;
      fill <= 2'h0;
    end else begin
      last <= q;
      if (!(&fill)) begin
        fill <= fill + 2'h1;
      end
    end
  end

  // Both rising and falling transitions count; a real change in the fill window is lost
  assign chg = (&fill) ? (q ^ last) : '0;
endmodule

// ### rtl/ppm_pin_cell.sv
`timescale 1ns/1ns
// Output selection for one pad: general-purpose data or one alternate source
module ppm_pin_cell (
  input wire logic [1:0] sel,
  input wire logic gpio_data,
  input wire logic gpio_dir,
  input wire logic alt_a,
  input wire logic alt_b,
  input wire logic alt_c,
  input wire logic [2:0] avail,
  input wire logic [2:0] analog,
  input wire logic release_pad,
  output logic out,
  output logic oe,
  output logic bias_en
);
  logic pick_a; // Alternate code A selected and offered
  logic pick_b; // Alternate code B selected and offered
  logic pick_c; // Alternate code C selected and offered
  logic digital_alt; // An alternate digital output owns the pad

  // An unoffered code falls back to general-purpose use
  assign pick_a = (sel == ppm_pkg::FSEL_A) & avail[0];
  assign pick_b = (sel == ppm_pkg::FSEL_B) & avail[1];
  assign pick_c = (sel == ppm_pkg::FSEL_C) & avail[2];
  assign bias_en = (pick_a & analog[0]) | (pick_b & analog[1]) | (pick_c & analog[2]);
  assign digital_alt = (pick_a | pick_b | pick_c) & ~bias_en;

  // One source at most: the select is a single code, so codes are exclusive
  assign out = pick_a ? alt_a : pick_b ? alt_b : pick_c ? alt_c : gpio_data;
  // Bias and comparator routing release the driver
  assign oe = ~release_pad & ~bias_en & (digital_alt | gpio_dir);
endmodule

// ### rtl/ppm_top.sv
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - Port A bit 0 interrupts on both edges
// - Port B bit 0 interrupts on both edges
// - Port A input enable zero blocks wake-up
// - Port B input enable bit n blocks wake-up
// - Each pin: direction, data, pull-high per pin
// - Port A bit 0: comparator, generator 0, bias
// - Port B 5-7: timer 3; generators 1/0
// - Port B 2,4: timer 2; bit 4 generator 0
// - Port B 2,3: wide generator 2 output
// - Port B 7,6 route to comparator minus
// - Port B bit 0: LCD common one bias
// - Port B bit 1: general-purpose only
module ppm_top (
  input wire logic MCLK,
  input wire logic RESETN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Port A bit 0 pad
  input wire logic PORT_A_BIT_ZERO_IN,
  output logic PORT_A_BIT_ZERO_OUT,
  output logic PORT_A_BIT_ZERO_OE,
  output logic PORT_A_BIT_ZERO_PULL_EN,
  // Port B pads
  input wire logic [7:0] PB_IN,
  output logic [7:0] PB_OUT,
  output logic [7:0] PB_OE,
  output logic [7:0] PB_PULL_EN,
  // Alternate output sources, same clock
  input wire logic COMPARATOR_OUT,
  input wire logic WIDE_PWM_GEN0_OUT,
  input wire logic WIDE_PWM_GEN1_OUT,
  input wire logic WIDE_PWM_GEN2_OUT,
  input wire logic TIMER_TWO_PWM_OUT,
  input wire logic TIMER_THREE_PWM_OUT,
  // Analog routing controls
  output logic LCD_COMMON_TWO_EN,
  output logic LCD_COMMON_ONE_EN,
  output logic CMP_MINUS_SRC_TWO_EN,
  output logic CMP_MINUS_SRC_THREE_EN,
  // Events
  output logic EXT_IRQ_LINE_ZERO,
  output logic EXT_IRQ_LINE_ONE,
  output logic WAKE,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////
  // Register state
  logic [8:0] data_r; // Output data, index 0 is port A bit 0
  logic [8:0] dir_r; // One selects output
  logic [8:0] pull_r; // Pull-high enables
  logic [8:0] dier_r; // Digital input enables
  logic [17:0] func_r; // Two-bit function code per pin
  logic [1:0] cmp_r; // Comparator minus routing
  logic [2:0] status_r; // Sticky event bits
  logic [2:0] mask_r; // Interrupt enables

  // Bus data-phase state
  logic wr_pend; // A write is in its data phase
  logic [7:0] addr_q; // Captured byte address

  ////////////////////////////////////////////////////////////////////
  // Bus address decode
  wire addr_take = HSEL & HREADY & (HTRANS == ppm_pkg::HTRANS_NONSEQ);
  wire wr_take = addr_take & HWRITE;
  wire rd_take = addr_take & ~HWRITE;

  // The slave never stalls and never signals an error
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Capture the write address for the following data phase
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_pend <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend <= wr_take;
      if (addr_take) begin
        addr_q <= HADDR[7:0];
      end
    end
  end

  // Register-select strobes, qualified by the data phase
  wire wr_pa_data = wr_pend & (addr_q == ppm_pkg::OFF_PA_DATA);
  wire wr_pa_dir = wr_pend & (addr_q == ppm_pkg::OFF_PA_DIR);
  wire wr_pa_pull = wr_pend & (addr_q == ppm_pkg::OFF_PA_PULL);
  wire wr_pa_dier = wr_pend & (addr_q == ppm_pkg::OFF_PA_DIER);
  wire wr_pb_data = wr_pend & (addr_q == ppm_pkg::OFF_PB_DATA);
  wire wr_pb_dir = wr_pend & (addr_q == ppm_pkg::OFF_PB_DIR);
  wire wr_pb_pull = wr_pend & (addr_q == ppm_pkg::OFF_PB_PULL);
  wire wr_pb_dier = wr_pend & (addr_q == ppm_pkg::OFF_PB_DIER);
  wire wr_func = wr_pend & (addr_q == ppm_pkg::OFF_FUNC_SEL);
  wire wr_cmp = wr_pend & (addr_q == ppm_pkg::OFF_CMP_ROUTE);
  wire wr_status = wr_pend & (addr_q == ppm_pkg::OFF_IRQ_STATUS);
  wire wr_mask = wr_pend & (addr_q == ppm_pkg::OFF_IRQ_MASK);

  // Merge a port A or port B write into the shared pin vectors
  function automatic logic [8:0] merge(input logic [8:0] cur, input logic wa,
                                       input logic wb, input logic [31:0] wd);
    logic [8:0] res;
    res = cur;
    if (wa) begin
      res[ppm_pkg::PA_BIT] = wd[0];
    end
    if (wb) begin
      res[ppm_pkg::PB_HI:ppm_pkg::PB_LO] = wd[7:0];
    end
    return res;
  endfunction

  wire [8:0] next_data = merge(data_r, wr_pa_data, wr_pb_data, HWDATA);
  wire [8:0] next_dir = merge(dir_r, wr_pa_dir, wr_pb_dir, HWDATA);
  wire [8:0] next_pull = merge(pull_r, wr_pa_pull, wr_pb_pull, HWDATA);
  wire [8:0] next_dier = merge(dier_r, wr_pa_dier, wr_pb_dier, HWDATA);

  ////////////////////////////////////////////////////////////////////
  // Pin configuration registers
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      data_r <= ppm_pkg::RST_DATA;
      dir_r <= ppm_pkg::RST_DIR;
      pull_r <= ppm_pkg::RST_PULL;
      dier_r <= ppm_pkg::RST_DIER;
    end else begin
      data_r <= next_data;
      dir_r <= next_dir;
      pull_r <= next_pull;
      dier_r <= next_dier;
    end
  end

  // Function and routing selects
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      func_r <= ppm_pkg::RST_FUNC;
      cmp_r <= ppm_pkg::RST_CMP;
    end else begin
      if (wr_func) begin
        func_r <= HWDATA[17:0];
      end
      if (wr_cmp) begin
        cmp_r <= HWDATA[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pad input synchronisation and transition detection
  logic [8:0] pin_sync; // Settled pad levels
  logic [8:0] pin_chg; // One-cycle pulse on either edge

  ppm_sync #(
    .WIDTH(ppm_pkg::NPIN)
  ) u_sync (
    .clk(MCLK),
    .rst_n(RESETN),
    .d({PB_IN, PORT_A_BIT_ZERO_IN}),
    .q(pin_sync),
    .chg(pin_chg)
  );

  // Disabled digital inputs read as zero and cannot wake
  wire [8:0] pin_seen = pin_sync & dier_r;
  wire [8:0] wake_chg = pin_chg & dier_r;
  wire wake_any = |wake_chg;

  // Either transition of each interrupt line requests service
  wire line_zero_evt = pin_chg[ppm_pkg::PA_BIT];
  wire line_one_evt = pin_chg[ppm_pkg::PB_LO];

  ////////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  wire [2:0] evt_set = {wake_any, line_one_evt, line_zero_evt};
  wire [2:0] status_clr = wr_status ? HWDATA[2:0] : 3'h0;
  // An event in the clearing cycle survives the clear
  wire [2:0] next_status = (status_r & ~status_clr) | evt_set;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      status_r <= 3'h0;
      mask_r <= ppm_pkg::RST_MASK;
    end else begin
      status_r <= next_status;
      if (wr_mask) begin
        mask_r <= HWDATA[2:0];
      end
    end
  end

  // Event pulses leave from flops, one cycle after detection
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      EXT_IRQ_LINE_ZERO <= 1'b0;
      EXT_IRQ_LINE_ONE <= 1'b0;
      WAKE <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      EXT_IRQ_LINE_ZERO <= line_zero_evt;
      EXT_IRQ_LINE_ONE <= line_one_evt;
      WAKE <= wake_any;
      IRQ <= |(next_status & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Alternate source table per pin index
  logic [8:0] alt_a; // Code 1 sources
  logic [8:0] alt_b; // Code 2 sources
  logic [8:0] alt_c; // Code 3 sources
  logic [8:0] release_pad; // Pad handed to the comparator input

  // Port A bit 0: comparator, wide generator 0, LCD common two
  assign alt_a[0] = COMPARATOR_OUT;
  assign alt_b[0] = WIDE_PWM_GEN0_OUT;
  // Port B bit 0 code 1 is bias only; bit 1 offers nothing
  assign alt_a[1] = 1'b0;
  assign alt_b[1] = 1'b0;
  assign alt_a[2] = 1'b0;
  assign alt_b[2] = 1'b0;
  // Port B bit 2: timer 2, wide generator 2
  assign alt_a[3] = TIMER_TWO_PWM_OUT;
  assign alt_b[3] = WIDE_PWM_GEN2_OUT;
  // Port B bit 3: wide generator 2
  assign alt_a[4] = WIDE_PWM_GEN2_OUT;
  assign alt_b[4] = 1'b0;
  // Port B bit 4: timer 2, wide generator 0
  assign alt_a[5] = TIMER_TWO_PWM_OUT;
  assign alt_b[5] = WIDE_PWM_GEN0_OUT;
  // Port B bit 5: timer 3, wide generator 0
  assign alt_a[6] = TIMER_THREE_PWM_OUT;
  assign alt_b[6] = WIDE_PWM_GEN0_OUT;
  // Port B bits 6 and 7: timer 3, wide generator 1
  assign alt_a[7] = TIMER_THREE_PWM_OUT;
  assign alt_b[7] = WIDE_PWM_GEN1_OUT;
  assign alt_a[8] = TIMER_THREE_PWM_OUT;
  assign alt_b[8] = WIDE_PWM_GEN1_OUT;
  // Only port A bit 0 has a third code, which is bias
  assign alt_c = 9'h000;

  // Comparator routing floats the pad whatever its function code
  assign release_pad[ppm_pkg::CMP_SRC_TWO_PIN] = cmp_r[ppm_pkg::CMP_SRC_TWO_BIT];
  assign release_pad[ppm_pkg::CMP_SRC_THREE_PIN] = cmp_r[ppm_pkg::CMP_SRC_THREE_BIT];
  assign release_pad[6:0] = 7'h00;

  ////////////////////////////////////////////////////////////////////
  // Pad cells
  logic [8:0] cell_out; // Selected output level
  logic [8:0] cell_oe; // Selected driver enable
  logic [8:0] cell_bias; // Pad given to LCD bias

  genvar gi;
  generate
    for (gi = 0; gi < ppm_pkg::NPIN; gi++) begin : g_pin
      ppm_pin_cell u_cell (
        .sel(func_r[gi*ppm_pkg::FSEL_W +: ppm_pkg::FSEL_W]),
        .gpio_data(data_r[gi]),
        .gpio_dir(dir_r[gi]),
        .alt_a(alt_a[gi]),
        .alt_b(alt_b[gi]),
        .alt_c(alt_c[gi]),
        .avail({ppm_pkg::AVAIL_C[gi], ppm_pkg::AVAIL_B[gi], ppm_pkg::AVAIL_A[gi]}),
        .analog({ppm_pkg::ANALOG_C[gi], 1'b0, ppm_pkg::ANALOG_A[gi]}),
        .release_pad(release_pad[gi]),
        .out(cell_out[gi]),
        .oe(cell_oe[gi]),
        .bias_en(cell_bias[gi])
      );
    end
  endgenerate

  // Pad outputs are registered so no glitch of the select reaches a pin
  logic [8:0] pad_out; // Registered pad level
  logic [8:0] pad_oe; // Registered driver enable
  logic [8:0] pad_bias; // Registered bias enable

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      pad_out <= 9'h000;
      pad_oe <= 9'h000;
      pad_bias <= 9'h000;
    end else begin
      pad_out <= cell_out;
      pad_oe <= cell_oe;
      pad_bias <= cell_bias;
    end
  end

  assign PORT_A_BIT_ZERO_OUT = pad_out[ppm_pkg::PA_BIT];
  assign PORT_A_BIT_ZERO_OE = pad_oe[ppm_pkg::PA_BIT];
  assign PORT_A_BIT_ZERO_PULL_EN = pull_r[ppm_pkg::PA_BIT];
  assign PB_OUT = pad_out[ppm_pkg::PB_HI:ppm_pkg::PB_LO];
  assign PB_OE = pad_oe[ppm_pkg::PB_HI:ppm_pkg::PB_LO];
  assign PB_PULL_EN = pull_r[ppm_pkg::PB_HI:ppm_pkg::PB_LO];
  assign LCD_COMMON_TWO_EN = pad_bias[ppm_pkg::PA_BIT];
  assign LCD_COMMON_ONE_EN = pad_bias[ppm_pkg::PB_LO];
  assign CMP_MINUS_SRC_TWO_EN = cmp_r[ppm_pkg::CMP_SRC_TWO_BIT];
  assign CMP_MINUS_SRC_THREE_EN = cmp_r[ppm_pkg::CMP_SRC_THREE_BIT];

  ////////////////////////////////////////////////////////////////////
  // Read-back mux; unmapped offsets read zero
  wire [31:0] rd_pa_data = {31'h0, data_r[ppm_pkg::PA_BIT]};
  wire [31:0] rd_pa_dir = {31'h0, dir_r[ppm_pkg::PA_BIT]};
  wire [31:0] rd_pa_pull = {31'h0, pull_r[ppm_pkg::PA_BIT]};
  wire [31:0] rd_pa_dier = {31'h0, dier_r[ppm_pkg::PA_BIT]};
  wire [31:0] rd_pb_data = {24'h0, data_r[ppm_pkg::PB_HI:ppm_pkg::PB_LO]};
  wire [31:0] rd_pb_dir = {24'h0, dir_r[ppm_pkg::PB_HI:ppm_pkg::PB_LO]};
  wire [31:0] rd_pb_pull = {24'h0, pull_r[ppm_pkg::PB_HI:ppm_pkg::PB_LO]};
  wire [31:0] rd_pb_dier = {24'h0, dier_r[ppm_pkg::PB_HI:ppm_pkg::PB_LO]};
  wire [31:0] rd_state = {16'h0, pin_seen[ppm_pkg::PB_HI:ppm_pkg::PB_LO],
                          7'h00, pin_seen[ppm_pkg::PA_BIT]};
  wire [7:0] ra = HADDR[7:0];
  wire [31:0] rd_word =
    (ra == ppm_pkg::OFF_PA_DATA) ? rd_pa_data :
    (ra == ppm_pkg::OFF_PA_DIR) ? rd_pa_dir :
    (ra == ppm_pkg::OFF_PA_PULL) ? rd_pa_pull :
    (ra == ppm_pkg::OFF_PA_DIER) ? rd_pa_dier :
    (ra == ppm_pkg::OFF_PB_DATA) ? rd_pb_data :
    (ra == ppm_pkg::OFF_PB_DIR) ? rd_pb_dir :
    (ra == ppm_pkg::OFF_PB_PULL) ? rd_pb_pull :
    (ra == ppm_pkg::OFF_PB_DIER) ? rd_pb_dier :
    (ra == ppm_pkg::OFF_FUNC_SEL) ? {14'h0, func_r} :
    (ra == ppm_pkg::OFF_CMP_ROUTE) ? {30'h0, cmp_r} :
    (ra == ppm_pkg::OFF_PIN_STATE) ? rd_state :
    (ra == ppm_pkg::OFF_IRQ_STATUS) ? {29'h0, status_r} :
    (ra == ppm_pkg::OFF_IRQ_MASK) ? {29'h0, mask_r} : 32'h00000000;

  // Read data is sampled at the address phase and stands in the data phase
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      HRDATA <= 32'h00000000;
    end else if (rd_take) begin
      HRDATA <= rd_word;
    end
  end
endmodule

// ### test/ppm_top_asserts.sv
`timescale 1ns/1ns
// Checks on the pad, event and routing outputs of the pin mux
module ppm_top_asserts (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic PORT_A_BIT_ZERO_IN,
  input wire logic [7:0] PB_IN,
  input wire logic PORT_A_BIT_ZERO_OE,
  input wire logic [7:0] PB_OUT,
  input wire logic [7:0] PB_OE,
  input wire logic LCD_COMMON_TWO_EN,
  input wire logic LCD_COMMON_ONE_EN,
  input wire logic CMP_MINUS_SRC_THREE_EN,
  input wire logic EXT_IRQ_LINE_ZERO,
  input wire logic EXT_IRQ_LINE_ONE,
  input wire logic WAKE
);
  default clocking dc @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  ////////////////////////////////////////////////////////////////////////////////
  logic [8:0] last_pins; // Pad levels one edge back
  logic [3:0] quiet; // Edges since a pad moved, saturating
  wire bus_wr = HSEL && HTRANS == ppm_pkg::HTRANS_NONSEQ && HWRITE; // Write address phase

  // A spurious change after reset only widens the window, so it never fires falsely
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      last_pins <= 9'h000;
      quiet <= 4'hF;
    end else begin
      last_pins <= {PB_IN, PORT_A_BIT_ZERO_IN};
      if (last_pins != {PB_IN, PORT_A_BIT_ZERO_IN}) begin
        quiet <= 4'h0;
      end else if (quiet != 4'hF) begin
        quiet <= quiet + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A pad flips and then holds while the synchroniser settles
  sequence zero_flip;
    $changed(PORT_A_BIT_ZERO_IN) ##1 $stable(PORT_A_BIT_ZERO_IN) [*3];
  endsequence
  sequence one_flip;
    $changed(PB_IN[0]) ##1 $stable(PB_IN[0]) [*3];
  endsequence

  line_zero_edge_a: assert property (zero_flip |-> ##[0:2] EXT_IRQ_LINE_ZERO)
    else $error("line zero missed a pad edge");
  line_one_edge_a: assert property (one_flip |-> ##[0:2] EXT_IRQ_LINE_ONE)
    else $error("line one missed a pad edge");
  zero_one_shot_a: assert property (EXT_IRQ_LINE_ZERO |=> !EXT_IRQ_LINE_ZERO)
    else $error("line zero pulse too long");
  wake_one_shot_a: assert property ($rose(WAKE) |=> $fell(WAKE))
    else $error("wake pulse too long");
  wake_has_cause_a: assert property (WAKE |-> quiet <= 4'h6)
    else $error("wake without a pad change");
  common_two_off_a: assert property (LCD_COMMON_TWO_EN |-> !PORT_A_BIT_ZERO_OE)
    else $error("bias pad still driven");
  common_one_off_a: assert property (LCD_COMMON_ONE_EN |-> !PB_OE[0])
    else $error("bias pad still driven");
  src_three_off_a: assert property (
    CMP_MINUS_SRC_THREE_EN && $past(CMP_MINUS_SRC_THREE_EN) |-> !PB_OE[7])
    else $error("comparator input pad still driven");
  plain_pad_a: assert property (
    !$stable({PB_OUT[1], PB_OE[1]})
    |-> $past(bus_wr, 2) || $past(bus_wr, 3) || $past(bus_wr, 4))
    else $error("plain pad moved without a write");
endmodule

bind ppm_top ppm_top_asserts u_chk (
  .MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .PORT_A_BIT_ZERO_IN(PORT_A_BIT_ZERO_IN), .PB_IN(PB_IN),
  .PORT_A_BIT_ZERO_OE(PORT_A_BIT_ZERO_OE), .PB_OUT(PB_OUT), .PB_OE(PB_OE),
  .LCD_COMMON_TWO_EN(LCD_COMMON_TWO_EN), .LCD_COMMON_ONE_EN(LCD_COMMON_ONE_EN),
  .CMP_MINUS_SRC_THREE_EN(CMP_MINUS_SRC_THREE_EN), .EXT_IRQ_LINE_ZERO(EXT_IRQ_LINE_ZERO),
  .EXT_IRQ_LINE_ONE(EXT_IRQ_LINE_ONE), .WAKE(WAKE)
);

// ### test/tb_io_port_pin_function_mux.sv
`timescale 1ns/1ns
// Register-level test of the pin function multiplexer
module tb_io_port_pin_function_mux;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic HSEL = 1'b1; // Single slave, always selected
  logic HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic PORT_A_BIT_ZERO_IN = 1'b0;
  logic [7:0] PB_IN = 8'h00;
  logic [5:0] src = 6'h00; // Sources: cmp, gen0, gen1, gen2, timer two, timer three
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, IRQ, WAKE;
  logic PORT_A_BIT_ZERO_OUT, PORT_A_BIT_ZERO_OE, PORT_A_BIT_ZERO_PULL_EN;
  logic [7:0] PB_OUT, PB_OE, PB_PULL_EN;
  logic LCD_COMMON_TWO_EN, LCD_COMMON_ONE_EN, CMP_MINUS_SRC_TWO_EN, CMP_MINUS_SRC_THREE_EN;
  logic EXT_IRQ_LINE_ZERO, EXT_IRQ_LINE_ONE;
  logic [2:0] ev; // Events seen: wake, line one, line zero
  int n_errors = 0;
  int compares = 0;
  // Function cases: pin index, code, source bit
  int tbl[13] = '{'h010, 'h021, 'h314, 'h323, 'h413, 'h514, 'h521, 'h615, 'h621,
                  'h715, 'h722, 'h815, 'h822};
  int sev[4] = '{'h105, 'h005, 'h016, 'h006}; // Pad levels and expected events

  always #50 MCLK = ~MCLK;

  ppm_top u_dut (
    .MCLK(MCLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PORT_A_BIT_ZERO_IN(PORT_A_BIT_ZERO_IN),
    .PORT_A_BIT_ZERO_OUT(PORT_A_BIT_ZERO_OUT), .PORT_A_BIT_ZERO_OE(PORT_A_BIT_ZERO_OE),
    .PORT_A_BIT_ZERO_PULL_EN(PORT_A_BIT_ZERO_PULL_EN), .PB_IN(PB_IN), .PB_OUT(PB_OUT),
    .PB_OE(PB_OE), .PB_PULL_EN(PB_PULL_EN), .COMPARATOR_OUT(src[0]),
    .WIDE_PWM_GEN0_OUT(src[1]), .WIDE_PWM_GEN1_OUT(src[2]), .WIDE_PWM_GEN2_OUT(src[3]),
    .TIMER_TWO_PWM_OUT(src[4]), .TIMER_THREE_PWM_OUT(src[5]),
    .LCD_COMMON_TWO_EN(LCD_COMMON_TWO_EN), .LCD_COMMON_ONE_EN(LCD_COMMON_ONE_EN),
    .CMP_MINUS_SRC_TWO_EN(CMP_MINUS_SRC_TWO_EN), .CMP_MINUS_SRC_THREE_EN(CMP_MINUS_SRC_THREE_EN),
    .EXT_IRQ_LINE_ZERO(EXT_IRQ_LINE_ZERO), .EXT_IRQ_LINE_ONE(EXT_IRQ_LINE_ONE),
    .WAKE(WAKE), .IRQ(IRQ)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Case equality so an unknown never passes
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single word transfer; waits on ready in both phases
  task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge MCLK);
    HTRANS <= ppm_pkg::HTRANS_NONSEQ;
    HWRITE <= wr;
    HADDR <= {24'h0, off};
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  task automatic wr(input logic [7:0] off, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, off, wd, rd);
  endtask

  task automatic rdc(input logic [7:0] off, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, off, 32'h0, rd);
    chk(rd, exp);
  endtask

  // Let registered outputs land, then look between edges
  task automatic settle(input int n);
    repeat (n) @(posedge MCLK);
    @(negedge MCLK);
  endtask

  // Move the pads and gather every event pulse in the following cycles
  task automatic pins(input logic pa, input logic [7:0] pb);
    @(posedge MCLK);
    PORT_A_BIT_ZERO_IN <= pa;
    PB_IN <= pb;
    ev = 3'h0;
    repeat (8) begin
      @(negedge MCLK);
      ev = ev | {WAKE, EXT_IRQ_LINE_ONE, EXT_IRQ_LINE_ZERO};
    end
  endtask

  task automatic test_done;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hang short; the sequence needs a few hundred cycles
  initial begin
    #(100 * 20000);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge MCLK);
    RESETN <= 1'b1;
    settle(4);
    rdc(ppm_pkg::OFF_PA_DIER, 32'h1);
    rdc(ppm_pkg::OFF_PB_DIER, 32'hFF);
    rdc(ppm_pkg::OFF_FUNC_SEL, 32'h0);
    rdc(8'h3C, 32'h0);
    chk({HREADYOUT, HRESP}, 32'h2);
    // Plain port use: direction, data and pull per pin
    wr(ppm_pkg::OFF_PB_DIR, 32'hFF);
    wr(ppm_pkg::OFF_PB_DATA, 32'hA5);
    wr(ppm_pkg::OFF_PB_PULL, 32'h3C);
    wr(ppm_pkg::OFF_PA_DIR, 32'h1);
    wr(ppm_pkg::OFF_PA_DATA, 32'h1);
    wr(ppm_pkg::OFF_PA_PULL, 32'h1);
    settle(2);
    chk({PB_OUT, PB_OE, PB_PULL_EN}, 32'hA5FF3C);
    chk({PORT_A_BIT_ZERO_OUT, PORT_A_BIT_ZERO_OE, PORT_A_BIT_ZERO_PULL_EN}, 32'h7);
    wr(ppm_pkg::OFF_PB_DIR, 32'h5A);
    wr(ppm_pkg::OFF_PB_DATA, 32'h0);
    wr(ppm_pkg::OFF_PA_DATA, 32'h0);
    settle(2);
    chk({PB_OUT, PB_OE}, 32'h005A);
    wr(ppm_pkg::OFF_PB_DIR, 32'h0);
    wr(ppm_pkg::OFF_PA_DIR, 32'h0);
    // Each offered source wins over zero data and an input direction
    foreach (tbl[i]) begin
      wr(ppm_pkg::OFF_FUNC_SEL, ((tbl[i] >> 4) & 3) << (2 * (tbl[i] >> 8)));
      src <= 6'h01 << (tbl[i] & 7);
      settle(2);
      chk({PB_OUT, PORT_A_BIT_ZERO_OUT}, 32'h1 << (tbl[i] >> 8));
      chk({PB_OE, PORT_A_BIT_ZERO_OE}, 32'h1 << (tbl[i] >> 8));
      @(posedge MCLK);
      src <= ~(6'h01 << (tbl[i] & 7));
      settle(2);
      chk({PB_OUT, PORT_A_BIT_ZERO_OUT}, 32'h0);
    end
    for (int c = 1; c < 4; c++) begin
      wr(ppm_pkg::OFF_FUNC_SEL, c << 4);
      settle(2);
      chk({PB_OUT[1], PB_OE[1]}, 32'h0);
    end
    // Drivers requested as outputs, so only the bias codes or comparator routing can release them
    wr(ppm_pkg::OFF_PA_DIR, 32'h1);
    wr(ppm_pkg::OFF_PB_DIR, 32'h1);
    wr(ppm_pkg::OFF_FUNC_SEL, 32'h7);
    settle(2);
    chk({LCD_COMMON_TWO_EN, PORT_A_BIT_ZERO_OE}, 32'h2);
    chk({LCD_COMMON_ONE_EN, PB_OE[0]}, 32'h2);
    wr(ppm_pkg::OFF_FUNC_SEL, 32'h14000);
    wr(ppm_pkg::OFF_CMP_ROUTE, 32'h3);
    settle(2);
    chk({CMP_MINUS_SRC_TWO_EN, CMP_MINUS_SRC_THREE_EN, PB_OE[7:6]}, 32'hC);
    wr(ppm_pkg::OFF_CMP_ROUTE, 32'h0);
    wr(ppm_pkg::OFF_FUNC_SEL, 32'h0);
    // Both edges of both lines, each acknowledged by write-one-to-clear
    wr(ppm_pkg::OFF_IRQ_MASK, 32'h7);
    foreach (sev[i]) begin
      pins(sev[i][8], sev[i][7:4] == 1);
      chk(ev, sev[i][2:0]);
      chk(IRQ, 32'h1);
      rdc(ppm_pkg::OFF_IRQ_STATUS, sev[i][2:0]);
      wr(ppm_pkg::OFF_IRQ_STATUS, 32'h7);
      settle(1);
      chk(IRQ, 32'h0);
    end
    wr(ppm_pkg::OFF_IRQ_MASK, 32'h0);
    pins(1'b1, 8'h00);
    chk(IRQ, 32'h0);
    rdc(ppm_pkg::OFF_IRQ_STATUS, 32'h5);
    // Input enables cleared: lines still fire, wake does not until port B bit 5 is enabled again
    wr(ppm_pkg::OFF_PA_DIER, 32'h0);
    wr(ppm_pkg::OFF_PB_DIER, 32'h0);
    pins(1'b1, 8'hFF);
    chk(ev, 32'h2);
    pins(1'b0, 8'hFF);
    chk(ev, 32'h1);
    wr(ppm_pkg::OFF_PB_DIER, 32'h20);
    pins(1'b0, 8'hDF);
    chk(ev, 32'h4);
    rdc(ppm_pkg::OFF_PIN_STATE, 32'h0);
    pins(1'b1, 8'hFF);
    chk(ev, 32'h5);
    rdc(ppm_pkg::OFF_PIN_STATE, 32'h2000);
    test_done();
  end
endmodule
